// ---- rtl/vdi_device.sv ----
// Video data inserter: captions, copy bits and teletext on the luma path
//
// Design decisions made here: the address map and the plain strobed port.
`timescale 1ns/1ps
`include "vdi_map.svh"
module vdi_device (
  input wire logic i_clock,
  input wire logic i_rst_n,
  vdi_link_if.device link,
  input wire logic i_line_start,
  input wire logic [9:0] i_line_num,
  input wire logic i_field2,
  output logic [7:0] o_luma_code,
  output logic o_luma_insert,
  output logic o_ttx_active
);
  vdi_pkg::vdi_dev_state_t s_r;
  vdi_pkg::vdi_dev_state_t s_nxt;

  // ----------------------------------------
  // Teletext block lookup
  // ----------------------------------------
  function automatic logic ttx_hit(input logic [3:0][7:0] blk, input logic [7:0] map,
                                   input logic fld2, input logic [9:0] line);
    logic [9:0] base;
    logic hit;
    base = fld2 ? `VDI_TTX_BASE_F2 : `VDI_TTX_BASE_F1;
    hit = 1'b0;
    for (int i = 0; i < 4; i++) begin
      if ((fld2 ? map[3 - i] : map[7 - i]) &&
          (line >= base + {6'h0, blk[i][7:4]}) &&
          (line <= base + {6'h0, blk[i][3:0]})) begin
        hit = 1'b1;
      end
    end
    ttx_hit = hit;
  endfunction : ttx_hit

  logic cc_en;
  logic cc_line;
  logic cgms_line;
  logic [24:0] phase_sum;
  logic [10:0] lead;

  assign cc_en = i_field2 ? s_r.cfg1[`VDI_BIT_CC_EN2] : s_r.cfg1[`VDI_BIT_CC_EN1];
  assign cc_line = i_line_num == {2'b00, (i_field2 ? s_r.line2 : s_r.line1)};
  assign cgms_line = i_line_num == (i_field2 ? `VDI_CGMS_LINE_F2 : `VDI_CGMS_LINE_F1);
  assign phase_sum = {1'b0, s_r.phase} + {1'b0, s_r.inc};
  assign lead = `VDI_TTX_LEAD + {8'h0, s_r.cfg4[2:0]};

  // ----------------------------------------
  // Next state
  // ----------------------------------------
  always_comb begin
    s_nxt = s_r;
    s_nxt.rdata = 8'h00;
    // Register writes
    if (link.reg_wr) begin
      case (link.reg_addr)
        `VDI_REG_CFG_ONE: s_nxt.cfg1 = link.reg_wdata;
        `VDI_REG_CFG_THREE: s_nxt.cfg3 = link.reg_wdata;
        `VDI_REG_CFG_FOUR: s_nxt.cfg4 = link.reg_wdata;
        `VDI_REG_CGMS_A: s_nxt.cgms_stage[11:8] = link.reg_wdata[3:0];
        `VDI_REG_CGMS_B: s_nxt.cgms_stage[7:0] = link.reg_wdata;
        `VDI_REG_CGMS_C: begin
          s_nxt.cgms_shadow = {s_r.cgms_stage, link.reg_wdata};
        end
        `VDI_REG_BLOCK_MAP: s_nxt.map = link.reg_wdata;
        `VDI_REG_CC1_A: s_nxt.cc_stage1 = link.reg_wdata;
        `VDI_REG_CC1_B: begin
          s_nxt.cc_shadow1 = {link.reg_wdata, s_r.cc_stage1};
          s_nxt.cc_pend1 = 1'b1;
        end
        `VDI_REG_CC2_A: s_nxt.cc_stage2 = link.reg_wdata;
        `VDI_REG_CC2_B: begin
          s_nxt.cc_shadow2 = {link.reg_wdata, s_r.cc_stage2};
          s_nxt.cc_pend2 = 1'b1;
        end
        `VDI_REG_CCLINE1: s_nxt.line1 = link.reg_wdata;
        `VDI_REG_CCLINE2: s_nxt.line2 = link.reg_wdata;
        default: begin
          if (link.reg_addr >= `VDI_REG_BLOCK_0 && link.reg_addr < `VDI_REG_BLOCK_MAP) begin
            s_nxt.blk[2'(link.reg_addr - `VDI_REG_BLOCK_0)] = link.reg_wdata;
          end
        end
      endcase
    end
    // Register reads, answer in the next cycle
    if (link.reg_rd) begin
      case (link.reg_addr)
        `VDI_REG_CFG_ONE: s_nxt.rdata = s_r.cfg1;
        `VDI_REG_CFG_THREE: s_nxt.rdata = s_r.cfg3;
        `VDI_REG_CFG_FOUR: s_nxt.rdata = s_r.cfg4;
        `VDI_REG_STATUS: begin
          s_nxt.rdata = {2'b00, s_r.ovf, 4'h0};
          s_nxt.ovf = 2'b00;
        end
        `VDI_REG_CGMS_A: s_nxt.rdata = {4'h0, s_r.cgms_shadow[19:16]};
        `VDI_REG_CGMS_B: s_nxt.rdata = s_r.cgms_shadow[15:8];
        `VDI_REG_CGMS_C: s_nxt.rdata = s_r.cgms_shadow[7:0];
        `VDI_REG_BLOCK_MAP: s_nxt.rdata = s_r.map;
        `VDI_REG_CC1_A: s_nxt.rdata = s_r.cc_shadow1[7:0];
        `VDI_REG_CC1_B: s_nxt.rdata = s_r.cc_shadow1[15:8];
        `VDI_REG_CC2_A: s_nxt.rdata = s_r.cc_shadow2[7:0];
        `VDI_REG_CC2_B: s_nxt.rdata = s_r.cc_shadow2[15:8];
        `VDI_REG_CCLINE1: s_nxt.rdata = s_r.line1;
        `VDI_REG_CCLINE2: s_nxt.rdata = s_r.line2;
        default: begin
          if (link.reg_addr >= `VDI_REG_BLOCK_0 && link.reg_addr < `VDI_REG_BLOCK_MAP) begin
            s_nxt.rdata = s_r.blk[2'(link.reg_addr - `VDI_REG_BLOCK_0)];
          end
        end
      endcase
    end
    // Reload before the last one was sent; set wins over clear
    if (link.reg_wr && link.reg_addr == `VDI_REG_CC1_B && s_r.cc_pend1) begin
      s_nxt.ovf[0] = 1'b1;
    end
    if (link.reg_wr && link.reg_addr == `VDI_REG_CC2_B && s_r.cc_pend2) begin
      s_nxt.ovf[1] = 1'b1;
    end

    // Caption and copy-bit serializer
    case (s_r.ser)
      vdi_pkg::VDI_SER_IDLE: begin
        s_nxt.insert = 1'b0;
        s_nxt.luma = `VDI_LEVEL_LOW;
        if (i_line_start && cc_en && cc_line) begin
          s_nxt.ser = vdi_pkg::VDI_SER_RUN;
          s_nxt.phase = 24'h0;
          s_nxt.inc = `VDI_CC_INC;
          s_nxt.nbits = `VDI_CC_FRAME_BITS;
          if (i_field2) begin
            s_nxt.sh = {1'b0, (s_r.cc_pend2 ? s_r.cc_shadow2 : `VDI_CC_NULL_PAIR), 1'b1,
                        `VDI_CC_RUNIN};
            s_nxt.cc_pend2 = 1'b0;
          end else begin
            s_nxt.sh = {1'b0, (s_r.cc_pend1 ? s_r.cc_shadow1 : `VDI_CC_NULL_PAIR), 1'b1,
                        `VDI_CC_RUNIN};
            s_nxt.cc_pend1 = 1'b0;
          end
          // A write completing in this cycle stays pending
          if (link.reg_wr && link.reg_addr == `VDI_REG_CC1_B) begin
            s_nxt.cc_pend1 = 1'b1;
          end
          if (link.reg_wr && link.reg_addr == `VDI_REG_CC2_B) begin
            s_nxt.cc_pend2 = 1'b1;
          end
        end else if (i_line_start && s_r.cfg3[`VDI_BIT_CGMS_EN] && cgms_line) begin
          s_nxt.ser = vdi_pkg::VDI_SER_RUN;
          s_nxt.phase = 24'h0;
          s_nxt.inc = `VDI_CGMS_INC;
          s_nxt.nbits = `VDI_CGMS_FRAME_BITS;
          s_nxt.sh = {10'h000, {<<{s_r.cgms_shadow}}, 2'b01};
        end
      end
      vdi_pkg::VDI_SER_RUN: begin
        s_nxt.insert = 1'b1;
        s_nxt.luma = s_r.sh[0] ? `VDI_LEVEL_HIGH : `VDI_LEVEL_LOW;
        s_nxt.phase = phase_sum[23:0];
        if (phase_sum[24]) begin
          s_nxt.sh = {1'b0, s_r.sh[31:1]};
          s_nxt.nbits = s_r.nbits - 6'd1;
          if (s_r.nbits == 6'd1) begin
            s_nxt.ser = vdi_pkg::VDI_SER_IDLE;
          end
        end
      end
      default: s_nxt.ser = vdi_pkg::VDI_SER_IDLE;
    endcase

    // Teletext request window and sample tracking
    case (s_r.ttx)
      vdi_pkg::VDI_TTX_IDLE: begin
        if (i_line_start && ttx_hit(s_r.blk, s_r.map, i_field2, i_line_num)) begin
          s_nxt.ttx = vdi_pkg::VDI_TTX_WAIT;
          s_nxt.req = 1'b1;
          s_nxt.tcnt = 11'd0;
          s_nxt.tsamp = 2'd0;
          s_nxt.tpos = 6'd0;
          s_nxt.tbits = 9'd0;
        end
      end
      vdi_pkg::VDI_TTX_WAIT, vdi_pkg::VDI_TTX_DATA: begin
        if (s_r.ttx == vdi_pkg::VDI_TTX_DATA || s_r.tcnt == lead) begin
          s_nxt.ttx = vdi_pkg::VDI_TTX_DATA;
          s_nxt.insert = 1'b1;
          s_nxt.luma = link.teletext_serial_in ? `VDI_LEVEL_HIGH : `VDI_LEVEL_LOW;
          s_nxt.tsamp = s_r.tsamp + 2'd1;
          if (s_r.tsamp == (vdi_pkg::vdi_short_bit(s_r.tpos) ? 2'd2 : 2'd3)) begin
            s_nxt.tsamp = 2'd0;
            s_nxt.tpos = (s_r.tpos == `VDI_TTX_SEQ_LAST) ? 6'd0 : s_r.tpos + 6'd1;
            s_nxt.tbits = s_r.tbits + 9'd1;
            if (s_r.tbits == `VDI_TTX_BITS - 9'd1) begin
              s_nxt.ttx = vdi_pkg::VDI_TTX_TAIL;
            end
          end
        end
      end
      vdi_pkg::VDI_TTX_TAIL: begin
        s_nxt.insert = s_r.ser == vdi_pkg::VDI_SER_RUN;
        if (!s_r.req) begin
          s_nxt.ttx = vdi_pkg::VDI_TTX_IDLE;
        end
      end
      default: s_nxt.ttx = vdi_pkg::VDI_TTX_IDLE;
    endcase
    if (s_r.req) begin
      s_nxt.tcnt = s_r.tcnt + 11'd1;
      if (s_r.tcnt == `VDI_TTX_WINDOW - 11'd1) begin
        s_nxt.req = 1'b0;
      end
    end
  end

  // ----------------------------------------
  // State register
  // ----------------------------------------
  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      s_r <= '0;
      s_r.luma <= `VDI_LEVEL_LOW;
      s_r.cfg1 <= `VDI_CFG_RESET;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign link.reg_rdata = s_r.rdata;
  assign link.teletext_request = s_r.req;
  assign o_luma_code = s_r.luma;
  assign o_luma_insert = s_r.insert;
  assign o_ttx_active = s_r.req;
endmodule : vdi_device

// ---- rtl/vdi_host.sv ----
// Host end: register master toward the inserter and teletext buffer
`timescale 1ns/1ps
`include "vdi_map.svh"
module vdi_host (
  input wire logic i_clock,
  input wire logic i_rst_n,
  vdi_link_if.host link,
  input wire logic [7:0] i_addr,
  input wire logic [7:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [7:0] o_rdata,
  output logic o_sending
);
  vdi_pkg::vdi_host_state_t s_r;
  vdi_pkg::vdi_host_state_t s_nxt;
  logic [7:0] boff;

  assign boff = i_addr - `VDI_HREG_BUF_BASE;

  // ----------------------------------------
  // Next state
  // ----------------------------------------
  always_comb begin
    s_nxt = s_r;
    s_nxt.wr = 1'b0;
    s_nxt.rd = 1'b0;
    s_nxt.rdata = 8'h00;
    s_nxt.req_d = link.teletext_request;
    if (s_r.lrd_pend && !s_r.rd) begin
      s_nxt.lrdata = link.reg_rdata;
      s_nxt.lrd_pend = 1'b0;
    end
    if (i_wr) begin
      case (i_addr)
        `VDI_HREG_LINK_ADDR: s_nxt.laddr = i_wdata;
        `VDI_HREG_LINK_WDATA: begin
          s_nxt.addr = s_r.laddr;
          s_nxt.wdata = i_wdata;
          s_nxt.wr = 1'b1;
        end
        `VDI_HREG_LINK_READ: begin
          s_nxt.addr = s_r.laddr;
          s_nxt.rd = 1'b1;
          s_nxt.lrd_pend = 1'b1;
        end
        `VDI_HREG_TTX_DELAY: s_nxt.delay = i_wdata[2:0];
        default: begin
          if (i_addr >= `VDI_HREG_BUF_BASE && boff < 8'(`VDI_TTX_BUF_BYTES)) begin
            s_nxt.buffer[6'(boff)] = i_wdata;
          end
        end
      endcase
    end
    if (i_rd) begin
      case (i_addr)
        `VDI_HREG_LINK_ADDR: s_nxt.rdata = s_r.laddr;
        `VDI_HREG_LINK_RDATA: s_nxt.rdata = s_r.lrdata;
        `VDI_HREG_TTX_DELAY: s_nxt.rdata = {5'h00, s_r.delay};
        `VDI_HREG_STATUS: s_nxt.rdata = s_r.lines;
        default: begin
          if (i_addr >= `VDI_HREG_BUF_BASE && boff < 8'(`VDI_TTX_BUF_BYTES)) begin
            s_nxt.rdata = s_r.buffer[6'(boff)];
          end
        end
      endcase
    end

    // Teletext answer to the request
    case (s_r.hs)
      vdi_pkg::VDI_H_IDLE: begin
        s_nxt.sdata = 1'b0;
        if (link.teletext_request && !s_r.req_d) begin
          s_nxt.hs = vdi_pkg::VDI_H_DELAY;
          s_nxt.dcnt = 4'd1;
        end
      end
      vdi_pkg::VDI_H_DELAY: begin
        s_nxt.dcnt = s_r.dcnt + 4'd1;
        if (s_r.dcnt == 4'd1 + {1'b0, s_r.delay}) begin
          s_nxt.hs = vdi_pkg::VDI_H_SEND;
          s_nxt.samp = 2'd0;
          s_nxt.pos = 6'd0;
          s_nxt.bidx = 9'd0;
          s_nxt.sdata = s_r.buffer[0][0];
        end
      end
      vdi_pkg::VDI_H_SEND: begin
        s_nxt.samp = s_r.samp + 2'd1;
        if (s_r.samp == (vdi_pkg::vdi_short_bit(s_r.pos) ? 2'd2 : 2'd3)) begin
          s_nxt.samp = 2'd0;
          s_nxt.pos = (s_r.pos == `VDI_TTX_SEQ_LAST) ? 6'd0 : s_r.pos + 6'd1;
          s_nxt.bidx = s_r.bidx + 9'd1;
          s_nxt.sdata = s_r.buffer[6'((s_r.bidx + 9'd1) >> 3)][3'(s_r.bidx + 9'd1)];
          if (s_r.bidx == `VDI_TTX_BITS - 9'd1) begin
            s_nxt.hs = vdi_pkg::VDI_H_DONE;
            s_nxt.sdata = 1'b0;
            s_nxt.lines = s_r.lines + 8'd1;
          end
        end
      end
      vdi_pkg::VDI_H_DONE: begin
        if (!link.teletext_request) begin
          s_nxt.hs = vdi_pkg::VDI_H_IDLE;
        end
      end
      default: s_nxt.hs = vdi_pkg::VDI_H_IDLE;
    endcase
  end

  // ----------------------------------------
  // State register
  // ----------------------------------------
  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign link.reg_addr = s_r.addr;
  assign link.reg_wdata = s_r.wdata;
  assign link.reg_wr = s_r.wr;
  assign link.reg_rd = s_r.rd;
  assign link.teletext_serial_in = s_r.sdata;
  assign o_rdata = s_r.rdata;
  assign o_sending = s_r.hs == vdi_pkg::VDI_H_SEND;
endmodule : vdi_host

// ---- rtl/vdi_link_if.sv ----
// Link between the inserter and its host and teletext buffer
`timescale 1ns/1ps
interface vdi_link_if;
  logic [7:0] reg_addr;
  logic [7:0] reg_wdata;
  logic reg_wr;
  logic reg_rd;
  logic [7:0] reg_rdata;
  logic teletext_request;
  logic teletext_serial_in;

  modport device (
    input reg_addr, reg_wdata, reg_wr, reg_rd, teletext_serial_in,
    output reg_rdata, teletext_request
  );
  modport host (
    output reg_addr, reg_wdata, reg_wr, reg_rd, teletext_serial_in,
    input reg_rdata, teletext_request
  );
endinterface : vdi_link_if

// ---- rtl/vdi_map.svh ----
// Register offsets, field positions, reset values and timing counts
`ifndef VDI_MAP_SVH
`define VDI_MAP_SVH
// ----------------------------------------
// Device registers
// ----------------------------------------
`define VDI_REG_CFG_ONE 8'h01
`define VDI_REG_CFG_THREE 8'h03
`define VDI_REG_CFG_FOUR 8'h04
`define VDI_REG_STATUS 8'h09
`define VDI_REG_CGMS_A 8'h1f
`define VDI_REG_CGMS_B 8'h20
`define VDI_REG_CGMS_C 8'h21
`define VDI_REG_BLOCK_0 8'h22
`define VDI_REG_BLOCK_MAP 8'h26
`define VDI_REG_CC1_A 8'h27
`define VDI_REG_CC1_B 8'h28
`define VDI_REG_CC2_A 8'h29
`define VDI_REG_CC2_B 8'h2a
`define VDI_REG_CCLINE1 8'h2b
`define VDI_REG_CCLINE2 8'h2c
`define VDI_CFG_RESET 8'h00
`define VDI_BIT_CC_EN1 0
`define VDI_BIT_CC_EN2 1
`define VDI_BIT_CGMS_EN 5
`define VDI_BIT_OVF1 4
`define VDI_BIT_OVF2 5
// ----------------------------------------
// Host registers
// ----------------------------------------
`define VDI_HREG_LINK_ADDR 8'h00
`define VDI_HREG_LINK_WDATA 8'h01
`define VDI_HREG_LINK_READ 8'h02
`define VDI_HREG_LINK_RDATA 8'h03
`define VDI_HREG_TTX_DELAY 8'h04
`define VDI_HREG_STATUS 8'h05
`define VDI_HREG_BUF_BASE 8'h40
// ----------------------------------------
// Waveform content and levels
// ----------------------------------------
`define VDI_CC_NULL_PAIR 16'h8080
`define VDI_CC_RUNIN 14'h1555
`define VDI_CC_FRAME_BITS 6'd31
`define VDI_CGMS_FRAME_BITS 6'd22
`define VDI_CGMS_LINE_F1 10'd20
`define VDI_CGMS_LINE_F2 10'd283
`define VDI_TTX_BASE_F1 10'd7
`define VDI_TTX_BASE_F2 10'd270
`define VDI_LEVEL_LOW 8'h10
`define VDI_LEVEL_HIGH 8'h7e
// ----------------------------------------
// Timing
// ----------------------------------------
`define VDI_CLK_HZ 64'd40000000
`define VDI_CC_RATE_HZ 64'd503496
`define VDI_CGMS_RATE_HZ 64'd450450
`define VDI_CC_INC 24'((`VDI_CC_RATE_HZ << 24) / `VDI_CLK_HZ)
`define VDI_CGMS_INC 24'((`VDI_CGMS_RATE_HZ << 24) / `VDI_CLK_HZ)
`define VDI_TTX_WINDOW 11'd1402
`define VDI_TTX_BITS 9'd360
`define VDI_TTX_SEQ_LAST 6'd36
`define VDI_TTX_LEAD 11'd2
`define VDI_TTX_BUF_BYTES 45
`endif

// ---- rtl/vdi_pkg.sv ----
// Types and shared helpers of the video data inserter
package vdi_pkg;
  typedef enum logic [1:0] {
    VDI_SER_IDLE = 2'b00,
    VDI_SER_RUN = 2'b01
  } vdi_ser_t;

  typedef enum logic [1:0] {
    VDI_TTX_IDLE = 2'b00,
    VDI_TTX_WAIT = 2'b01,
    VDI_TTX_DATA = 2'b11,
    VDI_TTX_TAIL = 2'b10
  } vdi_ttx_t;

  typedef enum logic [1:0] {
    VDI_H_IDLE = 2'b00,
    VDI_H_DELAY = 2'b01,
    VDI_H_SEND = 2'b11,
    VDI_H_DONE = 2'b10
  } vdi_hst_t;

  typedef struct packed {
    logic [7:0] cfg1;
    logic [7:0] cfg3;
    logic [7:0] cfg4;
    logic [1:0] ovf;
    logic [11:0] cgms_stage;
    logic [19:0] cgms_shadow;
    logic [7:0] cc_stage1;
    logic [7:0] cc_stage2;
    logic [15:0] cc_shadow1;
    logic [15:0] cc_shadow2;
    logic cc_pend1;
    logic cc_pend2;
    logic [7:0] line1;
    logic [7:0] line2;
    logic [3:0][7:0] blk;
    logic [7:0] map;
    vdi_ser_t ser;
    logic [31:0] sh;
    logic [5:0] nbits;
    logic [23:0] phase;
    logic [23:0] inc;
    vdi_ttx_t ttx;
    logic [10:0] tcnt;
    logic [1:0] tsamp;
    logic [5:0] tpos;
    logic [8:0] tbits;
    logic req;
    logic [7:0] luma;
    logic insert;
    logic [7:0] rdata;
  } vdi_dev_state_t;

  typedef struct packed {
    logic [7:0] laddr;
    logic [7:0] lwdata;
    logic [7:0] lrdata;
    logic lrd_pend;
    logic [2:0] delay;
    logic [7:0] lines;
    logic [44:0][7:0] buffer;
    vdi_hst_t hs;
    logic req_d;
    logic [3:0] dcnt;
    logic [1:0] samp;
    logic [5:0] pos;
    logic [8:0] bidx;
    logic sdata;
    logic [7:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
    logic [7:0] rdata;
  } vdi_host_state_t;

  // Teletext bit that lasts three samples instead of four
  function automatic logic vdi_short_bit(input logic [5:0] pos);
    vdi_short_bit = (pos == 6'd9) || (pos == 6'd18) || (pos == 6'd27) || (pos == 6'd36);
  endfunction : vdi_short_bit
endpackage : vdi_pkg

// ---- sim/vdi_data_inserter_tb_top.sv ----
// Testbench joining the inserter and host ends
`timescale 1ns/1ps
`include "vdi_map.svh"
module vdi_data_inserter_tb_top;
  logic i_clock;
  logic i_rst_n;
  logic [7:0] sw_addr;
  logic [7:0] sw_wdata;
  logic sw_wr;
  logic sw_rd;
  logic [7:0] sw_rdata;
  logic sending;
  logic line_start;
  logic [9:0] line_num;
  logic field2;
  logic [7:0] luma;
  logic insert;
  logic ttx;
  int mismatches = 0;
  int compares = 0;
  int cyc = 0;
  int sbit [0:1401];
  vdi_link_if vdi_link_if_i ();
  vdi_host vdi_host_i (.i_clock(i_clock), .i_rst_n(i_rst_n), .link(vdi_link_if_i.host),
    .i_addr(sw_addr), .i_wdata(sw_wdata), .i_wr(sw_wr), .i_rd(sw_rd),
    .o_rdata(sw_rdata), .o_sending(sending));
  vdi_device vdi_device_i (.i_clock(i_clock), .i_rst_n(i_rst_n),
    .link(vdi_link_if_i.device), .i_line_start(line_start), .i_line_num(line_num),
    .i_field2(field2), .o_luma_code(luma), .o_luma_insert(insert), .o_ttx_active(ttx));
  vdi_link_monitor vdi_link_monitor_i (.i_clock(i_clock), .i_rst_n(i_rst_n),
    .reg_addr(vdi_link_if_i.reg_addr), .reg_wdata(vdi_link_if_i.reg_wdata),
    .reg_wr(vdi_link_if_i.reg_wr), .reg_rd(vdi_link_if_i.reg_rd),
    .reg_rdata(vdi_link_if_i.reg_rdata), .teletext_request(vdi_link_if_i.teletext_request),
    .teletext_serial_in(vdi_link_if_i.teletext_serial_in));
  // ------
  // Clock, checks and bus tasks
  // ------
  initial begin
    i_clock = 1'b0;
    forever #12.5 i_clock = ~i_clock;
  end
  always @(posedge i_clock) cyc <= cyc + 1;
  task automatic results();
    $display("Mismatches %0d, compares %0d", mismatches, compares);
    if (mismatches == 0 && compares > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : results
  task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
    compares++;
    if (got !== exp) begin
      mismatches++;
      $display("BAD %0t byte %h expected %h", $time, got, exp);
    end
  endtask : chk8
  task automatic chk1(input logic got, input logic exp);
    compares++;
    if (got !== exp) begin
      mismatches++;
      $display("BAD %0t bit %b expected %b", $time, got, exp);
    end
  endtask : chk1
  task automatic tick();
    @(posedge i_clock);
    #1;
  endtask : tick
  task automatic hwr(input logic [7:0] a, input logic [7:0] d);
    @(posedge i_clock);
    sw_addr <= a;
    sw_wdata <= d;
    sw_wr <= 1'b1;
    @(posedge i_clock);
    sw_wr <= 1'b0;
  endtask : hwr
  task automatic hrd(input logic [7:0] a, output logic [7:0] d);
    @(posedge i_clock);
    sw_addr <= a;
    sw_rd <= 1'b1;
    @(posedge i_clock);
    sw_rd <= 1'b0;
    #1;
    d = sw_rdata;
  endtask : hrd
  task automatic dwr(input logic [7:0] a, input logic [7:0] d);
    hwr(`VDI_HREG_LINK_ADDR, a);
    hwr(`VDI_HREG_LINK_WDATA, d);
  endtask : dwr
  task automatic drd(input logic [7:0] a, output logic [7:0] d);
    hwr(`VDI_HREG_LINK_ADDR, a);
    hwr(`VDI_HREG_LINK_READ, 8'h00);
    repeat (2) @(posedge i_clock);
    hrd(`VDI_HREG_LINK_RDATA, d);
  endtask : drd
  task automatic vline(input logic [9:0] n, input logic f2);
    @(posedge i_clock);
    line_num <= n;
    field2 <= f2;
    line_start <= 1'b1;
    @(posedge i_clock);
    line_start <= 1'b0;
  endtask : vline
  // ------
  // Expected waveforms
  // ------
  function automatic logic [31:0] cc(input logic [7:0] a, input logic [7:0] b);
    cc = {1'b0, b, a, 1'b1, `VDI_CC_RUNIN};
  endfunction : cc
  function automatic logic [31:0] cg(input logic [7:0] a, input logic [7:0] b,
                                     input logic [7:0] c);
    logic [19:0] d;
    d = {a[3:0], b, c};
    cg = 32'h1;
    for (int i = 0; i < 20; i++) cg[2 + i] = d[19 - i];
  endfunction : cg
  function automatic logic [7:0] tbyte(input int k);
    tbyte = 8'(k * 29 + 91);
  endfunction : tbyte
  function automatic logic tbit(input int b);
    logic [7:0] t;
    t = tbyte(b / 8);
    tbit = t[b % 8];
  endfunction : tbit
  task automatic frame(input int n, input real p, input logic [31:0] e);
    int r;
    int k;
    for (k = 0; k < 8 && insert !== 1'b1; k++) tick();
    r = cyc;
    for (k = 0; k < n; k++) begin
      while (cyc < r + int'((k + 0.5) * p)) tick();
      chk1(insert, 1'b1);
      chk8(luma, e[k] ? `VDI_LEVEL_HIGH : `VDI_LEVEL_LOW);
    end
    while (cyc < r + int'(n * p) + 4) tick();
    chk1(insert, 1'b0);
  endtask : frame
  task automatic ttx_check(input int nd);
    int k;
    int s;
    logic w;
    logic wp;
    for (k = 0; k < 12 && vdi_link_if_i.teletext_request !== 1'b1; k++) tick();
    wp = 1'b0;
    for (k = 0; k < 1420; k++) begin
      s = k - 1 - nd;
      w = (s >= 0 && s < 1402) ? tbit(sbit[s]) : 1'b0;
      chk1(vdi_link_if_i.teletext_request, k < 1401);
      chk1(ttx, k < 1401);
      chk1(sending, s >= 0 && s < 1402);
      chk1(vdi_link_if_i.teletext_serial_in, w);
      chk1(insert, s >= 1 && s <= 1402);
      if (s >= 1 && s <= 1402) chk8(luma, wp ? `VDI_LEVEL_HIGH : `VDI_LEVEL_LOW);
      wp = w;
      tick();
    end
  endtask : ttx_check
  // ------
  // Tests
  // ------
  initial begin
    #(25 * 60000);
    mismatches++;
    results();
  end
  initial begin
    logic [7:0] d;
    int i;
    int k;
    int s;
    s = 0;
    for (i = 0; i < 360; i++) begin
      for (k = 0; k < ((i % 37 % 9 == 0 && i % 37 != 0) ? 3 : 4); k++) sbit[s + k] = i;
      s = s + k;
    end
    {i_rst_n, sw_addr, sw_wdata, sw_wr, sw_rd, line_start, line_num, field2} = '0;
    repeat (10) @(posedge i_clock);
    i_rst_n <= 1'b1;
    tick();
    chk8(luma, `VDI_LEVEL_LOW);
    chk1(insert, 1'b0);
    chk1(ttx, 1'b0);
    chk1(sending, 1'b0);
    chk8(sw_rdata, 8'h00);
    chk1(vdi_link_if_i.teletext_request, 1'b0);
    drd(`VDI_REG_CFG_FOUR, d);
    chk8(d, `VDI_CFG_RESET);
    drd(8'h10, d);
    chk8(d, 8'h00);
    hwr(8'h30, 8'h55);
    hrd(8'h30, d);
    chk8(d, 8'h00);
    dwr(`VDI_REG_CCLINE1, 8'd21);
    dwr(`VDI_REG_CCLINE2, 8'd22);
    dwr(`VDI_REG_CFG_ONE, 8'h03);
    dwr(`VDI_REG_CC1_A, 8'h41);
    dwr(`VDI_REG_CC1_B, 8'h62);
    vline(10'd21, 1'b0);
    fork
      frame(31, 40.0e6 / 503496.0, cc(8'h41, 8'h62));
      begin
        repeat (300) @(posedge i_clock);
        dwr(`VDI_REG_CC1_A, 8'h13);
        dwr(`VDI_REG_CC1_B, 8'h24);
      end
    join
    vline(10'd21, 1'b0);
    frame(31, 40.0e6 / 503496.0, cc(8'h13, 8'h24));
    vline(10'd21, 1'b0);
    frame(31, 40.0e6 / 503496.0, cc(8'h80, 8'h80));
    dwr(`VDI_REG_CC2_A, 8'hc5);
    dwr(`VDI_REG_CC2_B, 8'h3e);
    vline(10'd22, 1'b1);
    frame(31, 40.0e6 / 503496.0, cc(8'hc5, 8'h3e));
    for (i = 0; i < 2; i++) begin
      dwr(`VDI_REG_CC1_A, 8'h31);
      dwr(`VDI_REG_CC1_B, 8'h32);
      dwr(`VDI_REG_CC2_A, 8'h33);
      dwr(`VDI_REG_CC2_B, 8'h34);
    end
    drd(`VDI_REG_STATUS, d);
    chk8(d & 8'h30, 8'h30);
    drd(`VDI_REG_STATUS, d);
    chk8(d & 8'h30, 8'h00);
    dwr(`VDI_REG_CGMS_A, 8'h0a);
    dwr(`VDI_REG_CGMS_B, 8'hc3);
    dwr(`VDI_REG_CGMS_C, 8'h5a);
    dwr(`VDI_REG_CFG_THREE, 8'h20);
    drd(`VDI_REG_CFG_THREE, d);
    chk8(d, 8'h20);
    vline(`VDI_CGMS_LINE_F1, 1'b0);
    frame(22, 40.0e6 / 450450.0, cg(8'h0a, 8'hc3, 8'h5a));
    vline(`VDI_CGMS_LINE_F2, 1'b1);
    frame(22, 40.0e6 / 450450.0, cg(8'h0a, 8'hc3, 8'h5a));
    dwr(`VDI_REG_CCLINE1, 8'd20);
    vline(`VDI_CGMS_LINE_F1, 1'b0);
    frame(31, 40.0e6 / 503496.0, cc(8'h31, 8'h32));
    for (i = 0; i < 2; i++) begin
      for (k = 0; k < 45; k++) hwr(`VDI_HREG_BUF_BASE + 8'(k), tbyte(k));
      dwr(`VDI_REG_CFG_FOUR, 8'(i * 7));
      drd(`VDI_REG_CFG_FOUR, d);
      chk8(d, 8'(i * 7));
      hwr(`VDI_HREG_TTX_DELAY, 8'(i * 7));
      dwr(`VDI_REG_BLOCK_0 + 8'(i * 3), 8'h55);
      dwr(`VDI_REG_BLOCK_MAP, (i == 1) ? 8'h01 : 8'h80);
      vline((i == 1) ? 10'd275 : 10'd12, 1'(i));
      ttx_check(i * 7);
      vline((i == 1) ? 10'd12 : 10'd275, ~1'(i));
      for (k = 0; k < 12; k++) begin
        tick();
        chk1(vdi_link_if_i.teletext_request, 1'b0);
      end
    end
    hrd(`VDI_HREG_STATUS, d);
    chk8(d, 8'h02);
    results();
  end
endmodule : vdi_data_inserter_tb_top

// ---- sim/vdi_link_monitor.sv ----
// Checker of the link between the inserter and the host end
`timescale 1ns/1ps
`include "vdi_map.svh"
module vdi_link_monitor (
  input wire logic i_clock,
  input wire logic i_rst_n,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_rdata,
  input wire logic teletext_request,
  input wire logic teletext_serial_in
);
  // ------
  // Helper state
  // ------
  logic [10:0] hi_r;
  logic [7:0] cfg3_r;
  logic [7:0] cfg4_r;
  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      hi_r <= 11'd0;
      cfg3_r <= `VDI_CFG_RESET;
      cfg4_r <= `VDI_CFG_RESET;
    end else begin
      hi_r <= teletext_request ? hi_r + 11'd1 : 11'd0;
      if (reg_wr && reg_addr == `VDI_REG_CFG_THREE) cfg3_r <= reg_wdata;
      if (reg_wr && reg_addr == `VDI_REG_CFG_FOUR) cfg4_r <= reg_wdata;
    end
  end
  // ------
  // Assertions
  // ------
  default clocking cb @(posedge i_clock);
  endclocking
  default disable iff (!i_rst_n);
  strobe_exclusive_a: assert property (!(reg_wr && reg_rd))
    else $error("link strobes together");
  read_idle_a: assert property (!reg_rd |=> reg_rdata == 8'h00)
    else $error("read data outside read slot");
  cfg3_read_a: assert property (
    reg_rd && reg_addr == `VDI_REG_CFG_THREE |=> reg_rdata == cfg3_r)
    else $error("config three readback wrong");
  cfg4_read_a: assert property (
    reg_rd && reg_addr == `VDI_REG_CFG_FOUR |=> reg_rdata == cfg4_r)
    else $error("config four readback wrong");
  unmapped_read_a: assert property (reg_rd && reg_addr == 8'h10 |=> reg_rdata == 8'h00)
    else $error("unmapped read not zero");
  req_length_a: assert property (
    $fell(teletext_request) |-> hi_r == `VDI_TTX_WINDOW)
    else $error("request window length wrong");
  req_bound_a: assert property (hi_r <= `VDI_TTX_WINDOW)
    else $error("request window too long");
  serial_lead_a: assert property (
    $rose(teletext_request) |-> !teletext_serial_in [*2])
    else $error("serial data before first edge");
  serial_quiet_a: assert property (
    (!teletext_request) [*8] |-> ##2 !teletext_serial_in)
    else $error("serial data while idle");
endmodule : vdi_link_monitor
